/* lcs_pkg.sv */
package lcs_pkg;

    // ****************************************
    // Timebase
    // ****************************************
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 50000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
    localparam int TCNT_W = 12;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_A_DRV = 8'hAC;
    localparam logic [7:0] IDX_A_FL = 8'hAD;
    localparam logic [7:0] IDX_B_DRV = 8'hAE;
    localparam logic [7:0] IDX_B_FL = 8'hAF;
    localparam logic [15:0] RST_VAL = 16'h0000;
    localparam logic [15:0] DRV_MASK = 16'h903F;
    localparam logic [15:0] FL_MASK = 16'hF333;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int B_ENA = 15;
    localparam int B_HIB = 12;
    localparam int B_MODE = 15;
    localparam int B_TRIG = 14;
    localparam int B_DRIVE = 13;
    localparam int B_RATE = 12;
    localparam int F_DUR = 8;
    localparam int F_OFF = 4;
    localparam int F_ON = 0;

    // ****************************************
    // Durations
    // ****************************************
    localparam int DUR_MS [4] = '{32, 64, 96, 1024};
    localparam int REPEAT_MS = 4000;
    localparam int RAMP_STEPS = 64;
    localparam int FL_RAMP_NS = 1950000;
    localparam int LED_RAMP_NS = 250000000;
    localparam int FL_STEP_CYC = FL_RAMP_NS / (CLK_NS * RAMP_STEPS);
    localparam int LED_STEP_DEF = LED_RAMP_NS / (CLK_NS * RAMP_STEPS);
    localparam logic [16:0] REP_TICKS = 17'(REPEAT_MS * 1000 / (TICK_NS / 1000));

    typedef enum logic [1:0] {LCS_OFF, LCS_RISE, LCS_ON, LCS_FALL} lcs_st_e;

    typedef struct packed {
        logic [15:0] drv;
        logic [15:0] fl;
        lcs_st_e st;
        logic [5:0] lvl;
        logic [14:0] dur;
        logic [19:0] stp;
        logic [16:0] rep;
        logic drv_prv;
        logic pin_prv;
    } lcs_ch_s;

    typedef struct packed {
        lcs_ch_s [1:0] ch;
        logic [TCNT_W-1:0] tcnt;
        logic tick;
        logic [31:0] rdata;
    } lcs_state_s;

endpackage : lcs_pkg

/* lcs_ctrl.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ns

module lcs_ctrl import lcs_pkg::*; #(
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int LED_STEP_CYC = LED_STEP_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic hib_i,
    input wire logic sm_reset_i,
    input wire logic [1:0] flash_pin_i,
    output logic sink_a_pin_o,
    output logic [5:0] sink_a_level_o,
    output logic sink_b_pin_o,
    output logic [5:0] sink_b_level_o
);

    // ****************************************
    // Parameter checks
    // ****************************************
    if (TICK_CYC < 1 || TICK_CYC > (1 << TCNT_W)) begin : g_tick_chk
        $error("TICK_CYC out of range");
    end
    if (LED_STEP_CYC < 1 || LED_STEP_CYC * 4 >= (1 << 20)) begin : g_step_chk
        $error("LED_STEP_CYC out of range");
    end

    lcs_state_s r_reg;
    lcs_state_s r_next;
    logic hit;
    logic [7:0] idx;
    logic wr;

    // ****************************************
    // Helpers
    // ****************************************

    // Returns the step counter reload of a nonzero ramp code; the counter also spends a cycle at zero.
    function automatic logic [19:0] step_cyc(input logic flash, input logic [1:0] code);
        logic [19:0] base;
        base = flash ? 20'(FL_STEP_CYC) : 20'(LED_STEP_CYC);
        return (base << (2'(code - 2'h1))) - 20'h00001;
    endfunction : step_cyc

    // Returns the flash length in ticks.
    function automatic logic [14:0] dur_ticks(input logic [1:0] code);
        return 15'(DUR_MS[code] * 1000 / (TICK_NS / 1000));
    endfunction : dur_ticks

    // Decodes a word-aligned byte address into a register hit.
    function automatic logic reg_hit(input logic [11:0] a);
        return a[1:0] == 2'h0 && a[11:2] >= 10'(IDX_A_DRV) && a[11:2] <= 10'(IDX_B_FL);
    endfunction : reg_hit

    // ****************************************
    // Bus decode
    // ****************************************

    // Zero-wait slave; unmapped addresses answer with an error.
    assign idx = paddr_i[9:2];
    assign hit = reg_hit(paddr_i);
    assign wr = psel_i && penable_i && pwrite_i && hit;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign prdata_o = r_reg.rdata;

    // Outputs follow the channel state flops.
    assign sink_a_pin_o = r_reg.ch[0].st != LCS_OFF;
    assign sink_a_level_o = r_reg.ch[0].lvl;
    assign sink_b_pin_o = r_reg.ch[1].st != LCS_OFF;
    assign sink_b_level_o = r_reg.ch[1].lvl;

    // ****************************************
    // Next state
    // ****************************************

    // Timebase, channel sequencers, register writes so software beats the sequencers, then sm_reset_i last.
    always_comb begin
        logic en;
        logic flash;
        logic trig;
        logic stop;
        logic step;
        logic [5:0] code;
        en = 1'b0;
        flash = 1'b0;
        trig = 1'b0;
        stop = 1'b0;
        step = 1'b0;
        code = 6'h00;
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.tcnt == TCNT_W'(TICK_CYC - 1)) begin
            r_next.tcnt = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.tcnt = r_reg.tcnt + 1'b1;
        end
        if (psel_i && !penable_i) begin
            case (idx)
                IDX_A_DRV: r_next.rdata = {16'h0000, r_reg.ch[0].drv};
                IDX_A_FL: r_next.rdata = {16'h0000, r_reg.ch[0].fl};
                IDX_B_DRV: r_next.rdata = {16'h0000, r_reg.ch[1].drv};
                IDX_B_FL: r_next.rdata = {16'h0000, r_reg.ch[1].fl};
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end
        for (int c = 0; c < 2; c++) begin
            en = r_reg.ch[c].drv[B_ENA] && !(hib_i && !r_reg.ch[c].drv[B_HIB]);
            code = r_reg.ch[c].drv[5:0];
            flash = r_reg.ch[c].fl[B_MODE];
            r_next.ch[c].drv_prv = r_reg.ch[c].fl[B_DRIVE];
            r_next.ch[c].pin_prv = flash_pin_i[c];
            // Free-running repeat timer while auto repeat is on.
            trig = 1'b0;
            if (!(flash && r_reg.ch[c].fl[B_RATE])) begin
                r_next.ch[c].rep = '0;
            end else if (r_reg.tick) begin
                if (r_reg.ch[c].rep == REP_TICKS - 17'h1) begin
                    r_next.ch[c].rep = '0;
                    trig = 1'b1;
                end else begin
                    r_next.ch[c].rep = r_reg.ch[c].rep + 17'h1;
                end
            end
            // Source is consulted only in flash mode.
            if (flash) begin
                if (r_reg.ch[c].fl[B_TRIG]) begin
                    trig = trig || (flash_pin_i[c] && !r_reg.ch[c].pin_prv);
                end else begin
                    trig = trig || (r_reg.ch[c].fl[B_DRIVE] && !r_reg.ch[c].drv_prv);
                end
            end
            // Flash timer counts from the trigger.
            stop = 1'b0;
            if (flash && r_reg.tick && r_reg.ch[c].st inside {LCS_RISE, LCS_ON}) begin
                if (r_reg.ch[c].dur == 15'h0000) begin
                    stop = 1'b1;
                end else begin
                    r_next.ch[c].dur = r_reg.ch[c].dur - 15'h0001;
                end
            end
            if (!flash && !r_reg.ch[c].fl[B_DRIVE]) begin
                stop = 1'b1;
            end
            if (stop && flash && !r_reg.ch[c].fl[B_TRIG]) begin
                r_next.ch[c].fl[B_DRIVE] = 1'b0;
            end
            step = r_reg.ch[c].stp == 20'h00000;
            if (r_reg.ch[c].st inside {LCS_RISE, LCS_FALL}) begin
                r_next.ch[c].stp = step ? r_reg.ch[c].stp : r_reg.ch[c].stp - 20'h00001;
            end
            case (r_reg.ch[c].st)
                LCS_OFF: begin
                    r_next.ch[c].lvl = 6'h00;
                end
                LCS_RISE: begin
                    if (step) begin
                        r_next.ch[c].stp = step_cyc(flash, r_reg.ch[c].fl[F_ON+:2]);
                        if (r_reg.ch[c].lvl >= code) begin
                            r_next.ch[c].lvl = code;
                            r_next.ch[c].st = LCS_ON;
                        end else begin
                            r_next.ch[c].lvl = r_reg.ch[c].lvl + 6'h01;
                        end
                    end
                end
                LCS_ON: begin
                    r_next.ch[c].lvl = code;
                end
                LCS_FALL: begin
                    if (step) begin
                        r_next.ch[c].stp = step_cyc(flash, r_reg.ch[c].fl[F_OFF+:2]);
                        if (r_reg.ch[c].lvl == 6'h00) begin
                            r_next.ch[c].st = LCS_OFF;
                        end else begin
                            r_next.ch[c].lvl = r_reg.ch[c].lvl - 6'h01;
                        end
                    end
                end
                default: begin
                    r_next.ch[c].st = LCS_OFF;
                end
            endcase
            // Start a ramp up, either instant or stepped.
            if ((flash && trig && r_reg.ch[c].st inside {LCS_OFF, LCS_FALL}) ||
                (!flash && r_reg.ch[c].fl[B_DRIVE] && r_reg.ch[c].st inside {LCS_OFF, LCS_FALL})) begin
                r_next.ch[c].dur = dur_ticks(r_reg.ch[c].fl[F_DUR+:2]);
                if (r_reg.ch[c].fl[F_ON+:2] == 2'h0) begin
                    r_next.ch[c].lvl = code;
                    r_next.ch[c].st = LCS_ON;
                end else begin
                    r_next.ch[c].st = LCS_RISE;
                    r_next.ch[c].stp = step_cyc(flash, r_reg.ch[c].fl[F_ON+:2]);
                end
            end else if (stop && r_reg.ch[c].st inside {LCS_RISE, LCS_ON}) begin
                if (r_reg.ch[c].fl[F_OFF+:2] == 2'h0) begin
                    r_next.ch[c].lvl = 6'h00;
                    r_next.ch[c].st = LCS_OFF;
                end else begin
                    r_next.ch[c].st = LCS_FALL;
                    r_next.ch[c].stp = step_cyc(flash, r_reg.ch[c].fl[F_OFF+:2]);
                end
            end
            if (!en) begin
                r_next.ch[c].st = LCS_OFF;
                r_next.ch[c].lvl = 6'h00;
            end
        end
        // Software writes land after the sequencers so a write beats the hardware clear; sm_reset_i still overrides them.
        if (wr) begin
            case (idx)
                IDX_A_DRV: r_next.ch[0].drv = pwdata_i[15:0] & DRV_MASK;
                IDX_A_FL: r_next.ch[0].fl = pwdata_i[15:0] & FL_MASK;
                IDX_B_DRV: r_next.ch[1].drv = pwdata_i[15:0] & DRV_MASK;
                IDX_B_FL: r_next.ch[1].fl = pwdata_i[15:0] & FL_MASK;
                default: r_next.tick = r_next.tick;
            endcase
        end
        if (sm_reset_i) begin
            for (int c = 0; c < 2; c++) begin
                r_next.ch[c].drv = RST_VAL;
                r_next.ch[c].fl = RST_VAL;
                r_next.ch[c].st = LCS_OFF;
                r_next.ch[c].lvl = 6'h00;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************

    // Registers the whole state.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_disable_off: assert property (!r_reg.ch[0].drv[B_ENA] |=> !sink_a_pin_o)
        else $error("sink A on while disabled");

    a_hib_off: assert property (hib_i && !r_reg.ch[0].drv[B_HIB] |=> !sink_a_pin_o)
        else $error("sink A on in hibernate");

    a_level_zero: assert property (!sink_a_pin_o |-> sink_a_level_o == 6'h00)
        else $error("level nonzero while off");

    a_led_drive: assert property (!r_reg.ch[0].fl[B_MODE] && r_reg.ch[0].fl[B_DRIVE] &&
        r_reg.ch[0].drv[B_ENA] && !hib_i && !sm_reset_i |=> sink_a_pin_o)
        else $error("LED drive did not switch on");

    a_flash_start: assert property (r_reg.ch[0].fl[B_MODE] && !r_reg.ch[0].fl[B_TRIG] &&
        $rose(r_reg.ch[0].fl[B_DRIVE]) && r_reg.ch[0].st == LCS_OFF && r_reg.ch[0].drv[B_ENA] &&
        !hib_i && !sm_reset_i |=> sink_a_pin_o)
        else $error("flash not started by drive bit");

    a_pin_mode: assert property (r_reg.ch[0].fl[B_MODE] && r_reg.ch[0].fl[B_TRIG] && !r_reg.ch[0].fl[B_RATE] &&
        r_reg.ch[0].st == LCS_OFF && !(flash_pin_i[0] && !r_reg.ch[0].pin_prv) |=> !sink_a_pin_o)
        else $error("flash started without pin edge");

    a_inst_on: assert property ($rose(sink_a_pin_o) && $past(r_reg.ch[0].fl[F_ON+:2]) == 2'h0 &&
        !$past(sm_reset_i) |-> sink_a_level_o == $past(r_reg.ch[0].drv[5:0]))
        else $error("instant switch-on not at full code");

    a_sm_reset: assert property (sm_reset_i |=> r_reg.ch[0].drv == RST_VAL && r_reg.ch[1].fl == RST_VAL
        && !sink_b_pin_o)
        else $error("state machine reset missed");

    a_b_enable: assert property (!r_reg.ch[1].drv[B_ENA] |=> !sink_b_pin_o)
        else $error("sink B on while disabled");

endmodule : lcs_ctrl

/* lcs_led_load.sv */
`timescale 1ns/1ns

// ****************************************
// LED string load on one sink pin
// ****************************************
module lcs_led_load (
    input wire logic clk_i,
    input wire logic pin_i,
    output int width_o
);
    int run = 0;
    int last = 0;

    // Counts the lit run and keeps its length once the sink lets go.
    always @(posedge clk_i) begin
        if (pin_i === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                last <= run;
            end
            run <= 0;
        end
    end

    // Last complete lit run, zero before the first one.
    assign width_o = last;
endmodule : lcs_led_load

/* lcs_ctrl_bench.sv */
`timescale 1ns/1ns

// ****************************************
// Bench for the current sink controller
// ****************************************
module lcs_ctrl_bench import lcs_pkg::*;;
    localparam int TC = 2;
    localparam logic [11:0] AD [4] = '{12'h2B0, 12'h2B4, 12'h2B8, 12'h2BC};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic hib_i = 1'b0;
    logic sm_reset_i = 1'b0;
    logic [1:0] flash_pin_i = 2'b00;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, sink_a_pin_o, sink_b_pin_o;
    logic [5:0] sink_a_level_o, sink_b_level_o;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic err;
    logic [5:0] c;
    int width;
    int error_cnt = 0;
    int n_compared = 0;
    int seed = 92;
    int exp_w;

    lcs_ctrl #(.TICK_CYC(TC), .LED_STEP_CYC(4)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .hib_i(hib_i),
        .sm_reset_i(sm_reset_i), .flash_pin_i(flash_pin_i), .sink_a_pin_o(sink_a_pin_o),
        .sink_a_level_o(sink_a_level_o), .sink_b_pin_o(sink_b_pin_o), .sink_b_level_o(sink_b_level_o));

    lcs_led_load u_load (.clk_i(clk_i), .pin_i(sink_a_pin_o), .width_o(width));

    // Free running 20 MHz clock.
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Compares one result and counts it.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // One APB transfer, held until pready is seen high, then one idle cycle.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    // Waits until sink A stops conducting; the watchdog bounds a hang.
    task wait_off();
        while (sink_a_pin_o === 1'b1) begin
            @(posedge clk_i);
        end
        cyc(2);
    endtask : wait_off

    // Prints the counts and the verdict, then stops.
    task tally_and_finish();
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (90000) @(posedge clk_i);
        error_cnt++;
        tally_and_finish();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cyc(12);
        rst_b_i <= 1'b1;
        cyc(1);
        for (int i = 0; i < 4; i++) rdc(AD[i], 32'h0);
        apb(1'b0, 12'h2C0, 32'h0);
        chk(32'(err), 32'h1);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            apb(1'b1, AD[i], rnd);
            rdc(AD[i], rnd & {16'h0, i[0] ? FL_MASK : DRV_MASK});
            apb(1'b1, AD[i], 32'h0);
        end
        c = 6'($random(seed)) | 6'h01;
        apb(1'b1, AD[0], {16'h0, 10'h200, c});
        apb(1'b1, AD[1], 32'h6000);
        cyc(2);
        chk(32'(sink_a_pin_o), 32'h1);
        chk(32'(sink_a_level_o), 32'(c));
        chk(32'(sink_b_pin_o), 32'h0);
        hib_i <= 1'b1;
        cyc(3);
        chk(32'(sink_a_pin_o), 32'h0);
        apb(1'b1, AD[0], {16'h0, 10'h240, c});
        cyc(2);
        chk(32'(sink_a_pin_o), 32'h1);
        hib_i <= 1'b0;
        apb(1'b1, AD[0], {26'h0, c});
        cyc(2);
        chk(32'(sink_a_pin_o), 32'h0);
        apb(1'b1, AD[1], 32'h0001);
        apb(1'b1, AD[0], 32'h803F);
        apb(1'b1, AD[1], 32'h2001);
        cyc(8);
        chk(32'(sink_a_level_o < 6'h3F), 32'h1);
        cyc(300);
        chk(32'(sink_a_level_o), 32'h3F);
        apb(1'b1, AD[1], 32'h0010);
        cyc(8);
        chk(32'(sink_a_pin_o), 32'h1);
        cyc(300);
        chk(32'(sink_a_pin_o), 32'h0);
        apb(1'b1, AD[1], 32'h0);
        apb(1'b1, AD[0], {16'h0, 10'h200, c});
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, AD[1], 32'hA000 | 32'(d << 8));
            cyc(2);
            chk(32'(sink_a_pin_o), 32'h1);
            wait_off();
            exp_w = DUR_MS[d] * 20 * TC;
            chk(32'(width >= exp_w - 3 && width <= exp_w + 3), 32'h1);
            rdc(AD[1], 32'h8000 | 32'(d << 8));
        end
        apb(1'b1, AD[1], 32'hE000);
        cyc(4);
        chk(32'(sink_a_pin_o), 32'h0);
        flash_pin_i <= 2'b01;
        cyc(1);
        flash_pin_i <= 2'b00;
        cyc(3);
        chk(32'(sink_a_pin_o), 32'h1);
        chk(32'(sink_b_pin_o), 32'h0);
        wait_off();
        exp_w = DUR_MS[0] * 20 * TC;
        chk(32'(width >= exp_w - 3 && width <= exp_w + 3), 32'h1);
        apb(1'b1, AD[1], 32'h0);
        apb(1'b1, AD[2], 32'h8000 | 32'(c));
        apb(1'b1, AD[3], 32'hA100);
        cyc(2);
        chk(32'(sink_b_pin_o), 32'h1);
        chk(32'(sink_b_level_o), 32'(c));
        chk(32'(sink_a_pin_o), 32'h0);
        sm_reset_i <= 1'b1;
        cyc(1);
        sm_reset_i <= 1'b0;
        cyc(2);
        chk(32'(sink_b_pin_o), 32'h0);
        for (int i = 0; i < 4; i++) rdc(AD[i], 32'h0);
        tally_and_finish();
    end
endmodule : lcs_ctrl_bench
